//--- hdl/cmp_regs_pkg.sv
// Package with register offsets, field layout and reset values of the comparator register bank.
package cmp_regs_pkg;
  localparam logic [7:0] CMP0_INPUT_SELECT_ADDR = 8'h9c;
  localparam logic [7:0] CMP1_MODE_SELECT_ADDR  = 8'h9e;
  localparam logic [7:0] CMP1_INPUT_SELECT_ADDR = 8'h9f;
  localparam int         RISE_IRQ_ENABLE_BIT    = 5;
  localparam int         FALL_IRQ_ENABLE_BIT    = 4;
  localparam int         MODE_LSB               = 0;
  localparam int         POS_SELECT_LSB         = 0;
  localparam int         NEG_SELECT_LSB         = 4;
  localparam logic [7:0] MODE_WRITE_MASK        = 8'h33;
  localparam logic [7:0] CMP0_INPUT_SELECT_RESET = 8'h77;
  localparam logic [7:0] CMP1_INPUT_SELECT_RESET = 8'h77;
  localparam logic [7:0] CMP1_MODE_SELECT_RESET  = 8'h02;
  localparam logic [23:0] CMP_POS_ROUTE_RESET   = 24'h004000;
  localparam logic [23:0] CMP_NEG_ROUTE_RESET   = 24'h008000;
  localparam logic [3:0] LAST_PIN_CODE          = 4'hb;
  localparam int         PIN_COUNT              = 24;

  typedef enum logic [1:0] {
    MODE_FASTEST = 2'b00,
    MODE_FAST    = 2'b01,
    MODE_SLOW    = 2'b10,
    MODE_SLOWEST = 2'b11
  } speed_mode_t;
endpackage

//--- hdl/cmp_select_if.sv
// Interface carrying a comparator's select codes and the decoded pin routing.
`timescale 1ns/1ps
`default_nettype none
interface cmp_select_if;
  logic [3:0]                       positiveCode;
  logic [3:0]                       negativeCode;
  logic [cmp_regs_pkg::PIN_COUNT-1:0] positiveRoute;
  logic [cmp_regs_pkg::PIN_COUNT-1:0] negativeRoute;
  modport decoder (input positiveCode, input negativeCode,
                   output positiveRoute, output negativeRoute);
  modport owner   (output positiveCode, output negativeCode,
                   input positiveRoute, input negativeRoute);
endinterface
`default_nettype wire

//--- hdl/cmp_input_decode.sv
// Decoder from one comparator's select codes to one-hot pin routing.
`timescale 1ns/1ps
`default_nettype none
module cmp_input_decode (
  cmp_select_if.decoder sel
);
  // Even pins for the positive side, odd pins for the negative side; codes above 11 route nothing.
  function automatic logic [cmp_regs_pkg::PIN_COUNT-1:0] route(input logic [3:0] code,
                                                               input logic       odd);
    logic [cmp_regs_pkg::PIN_COUNT-1:0] r;
    r = '0;
    if (code <= cmp_regs_pkg::LAST_PIN_CODE) begin
      r[{code, odd}] = 1'b1;
    end
    return r;
  endfunction

  assign sel.positiveRoute = route(sel.positiveCode, 1'b0);
  assign sel.negativeRoute = route(sel.negativeCode, 1'b1);
endmodule // cmp_input_decode
`default_nettype wire

//--- hdl/comparator_mode_and_input_select.sv
// Register bank for comparator 1 mode and both comparators' input multiplexer selects.
// How it works
// - Mode register bits 7:6 and 3:2 read as zero and ignore writes.
// - Mode bit 5 enables comparator 1's rising-edge interrupt.
// - Mode bit 4 enables comparator 1's falling-edge interrupt.
// - Mode bits 1:0 pick one of four speed and power modes, 00 fastest, 11 slowest.
// - Each comparator has its own input multiplexer routing port pins to its inputs.
// - Positive select codes 0 to 11 pick even pins of ports 0 to 2 in order, others none.
// - Negative select codes 0 to 11 pick odd pins of ports 0 to 2 in order, others none.
// - Comparator 1 has its own select register working like comparator 0's.
// - Both multiplexers may pick the same pin at once with no interlock.
// - Edge flags are set by hardware on output edges and cleared only by software.
`timescale 1ns/1ps
`default_nettype none
module comparator_mode_and_input_select (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Special-function register port.
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrite,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  // Comparator 1 edge flags, kept by the control register outside.
  input  wire logic        cmp1_rise_flag,
  input  wire logic        cmp1_fall_flag,
  // Comparator 1 configuration and request.
  output logic             cmp1_rise_irq_enable,
  output logic             cmp1_fall_irq_enable,
  output logic      [1:0]  cmp1_speed_power_mode,
  output logic             cmp1IrqRequest,
  // Multiplexer select codes and decoded routing.
  output logic      [3:0]  cmp0_positive_select,
  output logic      [3:0]  cmp0_negative_select,
  output logic      [3:0]  cmp1_positive_select,
  output logic      [3:0]  cmp1_negative_select,
  output logic      [23:0] cmp0PositiveRoute,
  output logic      [23:0] cmp0NegativeRoute,
  output logic      [23:0] cmp1PositiveRoute,
  output logic      [23:0] cmp1NegativeRoute
);
  // Stored register images.
  logic [7:0]  modeReg;
  logic [7:0]  modeNext;
  logic [7:0]  sel0Reg;
  logic [7:0]  sel0Next;
  logic [7:0]  sel1Reg;
  logic [7:0]  sel1Next;

  // Next values of the registered outputs.
  logic [7:0]  rdataNext;
  logic        irqNext;
  logic        riseEnableNext;
  logic        fallEnableNext;
  logic [1:0]  speedModeNext;
  logic [3:0]  pos0Next;
  logic [3:0]  neg0Next;
  logic [3:0]  pos1Next;
  logic [3:0]  neg1Next;
  logic [23:0] route0PosNext;
  logic [23:0] route0NegNext;
  logic [23:0] route1PosNext;
  logic [23:0] route1NegNext;

  // Address decode and interrupt causes.
  wire         selectMode;
  wire         selectSel0;
  wire         selectSel1;
  wire         hitMode;
  wire         hitSel0;
  wire         hitSel1;
  wire         riseCause;
  wire         fallCause;

  // The same address compare feeds both the write strobes and the read multiplexer.
  function automatic logic addrIs(input logic [7:0] addr,
                                  input logic [7:0] target);
    return addr == target;
  endfunction

  cmp_select_if sel0Bus ();
  cmp_select_if sel1Bus ();

  assign selectMode = addrIs(sfrAddr, cmp_regs_pkg::CMP1_MODE_SELECT_ADDR);
  assign selectSel0 = addrIs(sfrAddr, cmp_regs_pkg::CMP0_INPUT_SELECT_ADDR);
  assign selectSel1 = addrIs(sfrAddr, cmp_regs_pkg::CMP1_INPUT_SELECT_ADDR);
  assign hitMode    = sfrWrite && selectMode;
  assign hitSel0    = sfrWrite && selectSel0;
  assign hitSel1    = sfrWrite && selectSel1;

  // Unused bits never store, so they read back as zero without a separate read mask.
  assign modeNext = hitMode ? (sfrWdata & cmp_regs_pkg::MODE_WRITE_MASK) : modeReg;
  assign sel0Next = hitSel0 ? sfrWdata : sel0Reg;
  assign sel1Next = hitSel1 ? sfrWdata : sel1Reg;

  // Reads see the value after a same-cycle write, so software never reads a stale byte.
  assign rdataNext = selectMode ? modeNext :
                     selectSel0 ? sel0Next :
                     selectSel1 ? sel1Next : 8'h00;

  // Fields of the mode register.
  assign riseEnableNext = modeNext[cmp_regs_pkg::RISE_IRQ_ENABLE_BIT];
  assign fallEnableNext = modeNext[cmp_regs_pkg::FALL_IRQ_ENABLE_BIT];
  assign speedModeNext  = modeNext[cmp_regs_pkg::MODE_LSB +: 2];

  // Fields of the two select registers.
  assign pos0Next = sel0Next[cmp_regs_pkg::POS_SELECT_LSB +: 4];
  assign neg0Next = sel0Next[cmp_regs_pkg::NEG_SELECT_LSB +: 4];
  assign pos1Next = sel1Next[cmp_regs_pkg::POS_SELECT_LSB +: 4];
  assign neg1Next = sel1Next[cmp_regs_pkg::NEG_SELECT_LSB +: 4];

  // Flags are only read here; their set and clear live with the control register.
  assign riseCause = cmp1_rise_flag && riseEnableNext;
  assign fallCause = cmp1_fall_flag && fallEnableNext;
  assign irqNext   = riseCause || fallCause;

  // One decoder per comparator; nothing compares the two, so shared pins are allowed.
  assign sel0Bus.positiveCode = pos0Next;
  assign sel0Bus.negativeCode = neg0Next;
  assign sel1Bus.positiveCode = pos1Next;
  assign sel1Bus.negativeCode = neg1Next;
  assign route0PosNext = sel0Bus.positiveRoute;
  assign route0NegNext = sel0Bus.negativeRoute;
  assign route1PosNext = sel1Bus.positiveRoute;
  assign route1NegNext = sel1Bus.negativeRoute;

  cmp_input_decode decode0 (.sel(sel0Bus.decoder));
  cmp_input_decode decode1 (.sel(sel1Bus.decoder));

  // Mode register image.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modeReg <= cmp_regs_pkg::CMP1_MODE_SELECT_RESET;
    end else begin
      modeReg <= modeNext;
    end
  end

  // Comparator 0 select register image.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel0Reg <= cmp_regs_pkg::CMP0_INPUT_SELECT_RESET;
    end else begin
      sel0Reg <= sel0Next;
    end
  end

  // Comparator 1 select register image.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel1Reg <= cmp_regs_pkg::CMP1_INPUT_SELECT_RESET;
    end else begin
      sel1Reg <= sel1Next;
    end
  end

  // Outputs are registered copies of the next state so they line up with the stored registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sfrRdata       <= 8'h00;
      cmp1IrqRequest <= 1'b0;
    end else begin
      sfrRdata       <= rdataNext;
      cmp1IrqRequest <= irqNext;
    end
  end

  // Mode outputs.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp1_rise_irq_enable  <= cmp_regs_pkg::CMP1_MODE_SELECT_RESET[5];
      cmp1_fall_irq_enable  <= cmp_regs_pkg::CMP1_MODE_SELECT_RESET[4];
      cmp1_speed_power_mode <= cmp_regs_pkg::CMP1_MODE_SELECT_RESET[1:0];
    end else begin
      cmp1_rise_irq_enable  <= riseEnableNext;
      cmp1_fall_irq_enable  <= fallEnableNext;
      cmp1_speed_power_mode <= speedModeNext;
    end
  end

  // Comparator 0 select codes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp0_positive_select <= cmp_regs_pkg::CMP0_INPUT_SELECT_RESET[3:0];
      cmp0_negative_select <= cmp_regs_pkg::CMP0_INPUT_SELECT_RESET[7:4];
    end else begin
      cmp0_positive_select <= pos0Next;
      cmp0_negative_select <= neg0Next;
    end
  end

  // Comparator 1 select codes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp1_positive_select <= cmp_regs_pkg::CMP1_INPUT_SELECT_RESET[3:0];
      cmp1_negative_select <= cmp_regs_pkg::CMP1_INPUT_SELECT_RESET[7:4];
    end else begin
      cmp1_positive_select <= pos1Next;
      cmp1_negative_select <= neg1Next;
    end
  end

  // Comparator 0 routing; the reset pattern is the decode of the reset select code.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp0PositiveRoute <= cmp_regs_pkg::CMP_POS_ROUTE_RESET;
      cmp0NegativeRoute <= cmp_regs_pkg::CMP_NEG_ROUTE_RESET;
    end else begin
      cmp0PositiveRoute <= route0PosNext;
      cmp0NegativeRoute <= route0NegNext;
    end
  end

  // Comparator 1 routing.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp1PositiveRoute <= cmp_regs_pkg::CMP_POS_ROUTE_RESET;
      cmp1NegativeRoute <= cmp_regs_pkg::CMP_NEG_ROUTE_RESET;
    end else begin
      cmp1PositiveRoute <= route1PosNext;
      cmp1NegativeRoute <= route1NegNext;
    end
  end
endmodule // comparator_mode_and_input_select
`default_nettype wire

//--- verif/comparator_mode_and_input_select_chk.sv
// Concurrent checks on the comparator register bank ports.
`timescale 1ns/1ps
`default_nettype none
module comparator_mode_and_input_select_chk (
  // Clock, reset, register port and edge flags.
  input wire logic        sys_clk, reset, sfrWrite, cmp1_rise_flag, cmp1_fall_flag,
  input wire logic [7:0]  sfrAddr, sfrWdata, sfrRdata,
  // Mode, request and selects.
  input wire logic        cmp1_rise_irq_enable, cmp1_fall_irq_enable, cmp1IrqRequest,
  input wire logic [1:0]  cmp1_speed_power_mode,
  input wire logic [3:0]  cmp0_positive_select, cmp0_negative_select,
  input wire logic [3:0]  cmp1_positive_select, cmp1_negative_select,
  input wire logic [23:0] cmp0PositiveRoute, cmp0NegativeRoute,
  input wire logic [23:0] cmp1PositiveRoute, cmp1NegativeRoute
);
  logic modeWrite, sel0Write, sel1Write;
  assign modeWrite = sfrWrite && sfrAddr == cmp_regs_pkg::CMP1_MODE_SELECT_ADDR;
  assign sel0Write = sfrWrite && sfrAddr == cmp_regs_pkg::CMP0_INPUT_SELECT_ADDR;
  assign sel1Write = sfrWrite && sfrAddr == cmp_regs_pkg::CMP1_INPUT_SELECT_ADDR;
  // Pin index is port times eight plus pin, so codes above 11 route nowhere.
  function automatic logic [23:0] routeOf(logic [3:0] code, logic odd);
    logic [4:0] pin;
    pin = 5'({code[3:2], 3'h0}) + 5'({code[1:0], 1'b0}) + 5'(odd);
    return (code > 4'hb) ? 24'h0 : 24'h1 << pin;
  endfunction
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rsvd_read_zero: assert property (
    sfrAddr == cmp_regs_pkg::CMP1_MODE_SELECT_ADDR |=> (sfrRdata & 8'hcc) == 8'h00)
    else $error("Mode register unused bits read nonzero.");
  a_rise_enable_write: assert property (
    modeWrite |=> cmp1_rise_irq_enable == $past(sfrWdata[5]))
    else $error("Rising enable did not take the written bit.");
  a_fall_enable_write: assert property (
    modeWrite |=> cmp1_fall_irq_enable == $past(sfrWdata[4]))
    else $error("Falling enable did not take the written bit.");
  a_mode_field_write: assert property (
    modeWrite |=> cmp1_speed_power_mode == $past(sfrWdata[1:0]))
    else $error("Mode field did not take the written code.");
  a_cmp0_select_write: assert property (
    sel0Write |=> {cmp0_negative_select, cmp0_positive_select} == $past(sfrWdata))
    else $error("Comparator 0 selects did not take the written byte.");
  a_cmp1_select_write: assert property (
    sel1Write |=> {cmp1_negative_select, cmp1_positive_select} == $past(sfrWdata))
    else $error("Comparator 1 selects did not take the written byte.");
  a_cmp0_route_decode: assert property (
    cmp0PositiveRoute == routeOf(cmp0_positive_select, 1'b0) &&
    cmp0NegativeRoute == routeOf(cmp0_negative_select, 1'b1))
    else $error("Comparator 0 routing disagrees with its codes.");
  a_cmp1_route_decode: assert property (
    cmp1PositiveRoute == routeOf(cmp1_positive_select, 1'b0) &&
    cmp1NegativeRoute == routeOf(cmp1_negative_select, 1'b1))
    else $error("Comparator 1 routing disagrees with its codes.");
  // The request follows last cycle's flags against the enables as they now stand.
  a_irq_request_level: assert property (
    cmp1IrqRequest == (($past(cmp1_rise_flag) && cmp1_rise_irq_enable) ||
                       ($past(cmp1_fall_flag) && cmp1_fall_irq_enable)))
    else $error("Interrupt request disagrees with flags and enables.");
endmodule // comparator_mode_and_input_select_chk
bind comparator_mode_and_input_select comparator_mode_and_input_select_chk comparator_mode_and_input_select_chk_i (.*);
`default_nettype wire

//--- verif/tb_comparator_mode_and_input_select.sv
// Random-traffic bench comparing the comparator register bank with an integer model.
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_mode_and_input_select;
  logic        sys_clk = 1'b0, reset = 1'b1, sfrWrite = 1'b0;
  logic        cmp1_rise_flag = 1'b0, cmp1_fall_flag = 1'b0;
  logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
  logic        cmp1_rise_irq_enable, cmp1_fall_irq_enable, cmp1IrqRequest;
  logic [1:0]  cmp1_speed_power_mode;
  logic [3:0]  cmp0_positive_select, cmp0_negative_select, cmp1_positive_select, cmp1_negative_select;
  logic [23:0] cmp0PositiveRoute, cmp0NegativeRoute, cmp1PositiveRoute, cmp1NegativeRoute;
  int          modeReg, sel0, sel1, rdExp, irqExp, error_cnt, checked;
  wire   [7:0] modeView;
  assign modeView = {2'b00, cmp1_rise_irq_enable, cmp1_fall_irq_enable, 2'b00, cmp1_speed_power_mode};
  always #25 sys_clk = ~sys_clk;
  comparator_mode_and_input_select comparator_mode_and_input_select_i (.*);
  function automatic int routeOf(int code, int odd);
    return (code > 11) ? 0 : 1 << ((code / 4) * 8 + (code % 4) * 2 + odd);
  endfunction
  task automatic check_reg(logic [7:0] got, int exp);
    checked++;
    if (got !== exp[7:0]) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp[7:0]);
    end
  endtask
  task automatic check_route(logic [23:0] got, int exp);
    checked++;
    if (got !== exp[23:0]) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp[23:0]);
    end
  endtask
  task automatic model_step();
    if (sfrWrite && sfrAddr == 8'h9c) sel0 = sfrWdata;
    if (sfrWrite && sfrAddr == 8'h9e) modeReg = sfrWdata & 8'h33;
    if (sfrWrite && sfrAddr == 8'h9f) sel1 = sfrWdata;
    // The request follows the enables as they stand after a same-cycle write.
    irqExp = reset ? 0 : (cmp1_rise_flag && modeReg[5]) || (cmp1_fall_flag && modeReg[4]);
    rdExp = (sfrAddr == 8'h9c) ? sel0 : (sfrAddr == 8'h9e) ? modeReg : (sfrAddr == 8'h9f) ? sel1 : 0;
    modeReg = reset ? 2 : modeReg;
    sel0 = reset ? 'h77 : sel0;
    sel1 = reset ? 'h77 : sel1;
    rdExp = reset ? 0 : rdExp;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d.", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h17ad1f35));
    for (int i = 0; i < 2000; i++) begin
      @(posedge sys_clk);
      reset <= (i < 8) || ($urandom % 300 == 0);
      sfrWrite <= 1'($urandom % 2);
      sfrAddr <= ($urandom % 4 != 0) ? 8'h9c + 8'($urandom % 4) : 8'($urandom);
      // Pin setup is software's duty outside this block, so every select code is fair stimulus.
      sfrWdata <= 8'($urandom);
      cmp1_rise_flag <= 1'($urandom % 2);
      cmp1_fall_flag <= 1'($urandom % 2);
      @(negedge sys_clk);
      if (i > 0) begin
        check_reg(modeView, modeReg);
        check_reg({cmp0_negative_select, cmp0_positive_select}, sel0);
        check_reg({cmp1_negative_select, cmp1_positive_select}, sel1);
        check_reg(sfrRdata, rdExp);
        check_reg({7'h0, cmp1IrqRequest}, irqExp);
        check_route(cmp0PositiveRoute, routeOf(sel0 % 16, 0));
        check_route(cmp0NegativeRoute, routeOf(sel0 / 16, 1));
        check_route(cmp1PositiveRoute, routeOf(sel1 % 16, 0));
        check_route(cmp1NegativeRoute, routeOf(sel1 / 16, 1));
      end
      model_step();
      if (i == 9) $display("Reset value test done.");
    end
    $display("Random register traffic test done.");
    finish_test();
  end
  initial begin
    #105000;
    error_cnt++;
    finish_test();
  end
endmodule // tb_comparator_mode_and_input_select
`default_nettype wire
